/* design/ima_pkg.sv */
// What this block does
// - Outside edge and forced settings the alert is pulled low while a message is unread; in mode 0 only until the first is consumed before a STOP.
// - In mode 0 the alert is released once the first report identifier is acked and the next byte is loaded.
// - In mode 0 a STOP keeps the alert released if no message is left and reasserts it otherwise.
// - Reading the message object with no message pending returns report identifier 255.
// - In mode 1 the alert stays low while messages remain queued behind the current one.
// - In mode 1 the alert is released only after the report identifier of the last message is acked and the next byte loaded.
// - The configuration register selects the alert mode, an edge-style pulse and a software forced level.
// - SDA and SCL are only ever pulled low or released, never driven high.
// - SCL is held low while the next read byte is not ready, for at most about 15 ms per stretch.
// - When enabled the bus monitor resets the target logic if SDA or SCL stays low over 200 ms.
// - The bus monitor has an enable bit in the configuration register.
// - A NACK that ends a read restores the address pointer to the start of that read.
// - In a continuous message read the closing NACK returns the pointer to the message count object.
package ima_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int STRETCH_MS  = 15;
  localparam int BUSMON_MS   = 200;
  localparam int EDGE_NS     = 1000;
  // Longest times round down, least times are whole cycles already
  localparam int STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
  localparam int BUSMON_CYC  = (CLK_HZ / 1000) * BUSMON_MS;
  localparam int EDGE_CYC    = (CLK_HZ / 1_000_000) * EDGE_NS / 1000;
  localparam int TW          = 24;
  localparam int EW          = 8;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_INFO = 8'h0c;

  localparam int CFG_MODE  = 0;
  localparam int CFG_EDGE  = 1;
  localparam int CFG_FORCE = 2;
  localparam int CFG_FLVL  = 3;
  localparam int CFG_BMON  = 4;
  localparam int CFG_W     = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h10;

  localparam int ST_STUCK  = 0;
  localparam int ST_STRTO  = 1;
  localparam int ST_WRDONE = 2;
  localparam int ST_RDDONE = 3;
  localparam int ST_W      = 4;

  // ==========================================================
  // Bus values
  localparam logic [6:0]  TGT_ADDR_LO = 7'h4a;
  localparam logic [6:0]  TGT_ADDR_HI = 7'h4b;
  localparam logic [7:0]  RID_INVALID = 8'hff;
  localparam logic [15:0] CNT_ADDR_DEF = 16'h0100;
  localparam logic [15:0] MSG_ADDR_DEF = 16'h0101;
  localparam logic [7:0]  MSG_SIZE_DEF = 8'h0a;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  BIT_LAST    = 4'h7;

  typedef enum logic [2:0] {
    IMA_IDLE = 3'b000,
    IMA_ADDR = 3'b001,
    IMA_ACK  = 3'b010,
    IMA_WRB  = 3'b011,
    IMA_LOAD = 3'b100,
    IMA_RDB  = 3'b101,
    IMA_RACK = 3'b110
  } ima_st_e;

endpackage : ima_pkg

/* design/ima_line_if.sv */
`timescale 1ns/1ps
interface ima_line_if;
  logic sda;
  logic scl;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic stuck;
  logic mon_en;

  modport mon  (output sda, scl, start, stop, rise, fall, stuck, input mon_en);
  modport core (input sda, scl, start, stop, rise, fall, stuck, output mon_en);
endinterface : ima_line_if

/* design/ima_line_mon.sv */
`timescale 1ns/1ps
module ima_line_mon #(
  parameter int BUSMON_CYC = ima_pkg::BUSMON_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Raw bus levels
  input  wire logic sda_i,
  input  wire logic scl_i,
  // Conditioned events
  ima_line_if.mon   lk
);

  typedef struct packed {
    logic                     sda_m;
    logic                     sda_s;
    logic                     sda_p;
    logic                     scl_m;
    logic                     scl_s;
    logic                     scl_p;
    logic                     start;
    logic                     stop;
    logic                     rise;
    logic                     fall;
    logic                     stuck;
    logic [ima_pkg::TW-1:0]   cnt;
  } ima_mon_s;

  ima_mon_s s;
  ima_mon_s n;

  // ==========================================================
  // Synchronise, find edges, watch for a stuck line
  always_comb
  begin
    n       = s;
    n.sda_m = sda_i;
    n.sda_s = s.sda_m;
    n.sda_p = s.sda_s;
    n.scl_m = scl_i;
    n.scl_s = s.scl_m;
    n.scl_p = s.scl_s;
    n.start = s.sda_p & ~s.sda_s & s.scl_s & s.scl_p;
    n.stop  = ~s.sda_p & s.sda_s & s.scl_s & s.scl_p;
    n.rise  = ~s.scl_p & s.scl_s;
    n.fall  = s.scl_p & ~s.scl_s;
    n.stuck = 1'b0;
    if (lk.mon_en && (!s.sda_s || !s.scl_s))
    begin
      if (s.cnt == ima_pkg::TW'(BUSMON_CYC))
      begin
        n.stuck = 1'b1;
        n.cnt   = '0;
      end
      else
      begin
        n.cnt = s.cnt + 1'b1;
      end
    end
    else
    begin
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s       <= '0;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_p <= 1'b1;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_p <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign lk.sda   = s.sda_p;
  assign lk.scl   = s.scl_p;
  assign lk.start = s.start;
  assign lk.stop  = s.stop;
  assign lk.rise  = s.rise;
  assign lk.fall  = s.fall;
  assign lk.stuck = s.stuck;

endmodule : ima_line_mon

/* design/ima_target.sv */
`timescale 1ns/1ps
module ima_target #(
  parameter int          STRETCH_CYC = ima_pkg::STRETCH_CYC,
  parameter int          BUSMON_CYC  = ima_pkg::BUSMON_CYC,
  parameter logic [15:0] CNT_ADDR    = ima_pkg::CNT_ADDR_DEF,
  parameter logic [15:0] MSG_ADDR    = ima_pkg::MSG_ADDR_DEF,
  parameter logic [7:0]  MSG_SIZE    = ima_pkg::MSG_SIZE_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // Two-wire bus, open drain
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        addr_sel_i,
  // Message alert, open drain, active low
  output logic             message_alert_n_o,
  output logic             message_alert_n_oe_o,
  // Message queue
  input  wire logic [7:0]  msg_count_i,
  output logic             msg_pop_o,
  // Object memory
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        mem_ack_i
);

  typedef struct packed {
    ima_pkg::ima_st_e              st;
    logic [3:0]                    cnt;
    logic [7:0]                    sh;
    logic [7:0]                    tx;
    logic                          rw;
    logic                          ackok;
    logic [1:0]                    bidx;
    logic [15:0]                   ptr;
    logic [15:0]                   start;
    logic                          sda_oe;
    logic                          scl_oe;
    logic                          lo;
    logic                          freq;
    logic                          fetch;
    logic                          txv;
    logic [7:0]                    txb;
    logic                          txrid;
    logic                          rid_ld;
    logic                          pop_pend;
    logic                          hold0;
    logic [ima_pkg::TW-1:0]        strc;
    logic [ima_pkg::EW-1:0]        edge_cnt;
    logic [7:0]                    prev_cnt;
    logic                          alert_oe;
    logic [ima_pkg::CFG_W-1:0]     cfg;
    logic [ima_pkg::ST_W-1:0]      stat;
    logic [ima_pkg::ST_W-1:0]      mask;
    logic                          irq;
    logic                          wb_ack;
    logic [31:0]                   wb_dat;
    logic                          pop;
    logic                          mem_rd;
    logic                          mem_wr;
    logic [15:0]                   mem_addr;
    logic [7:0]                    mem_wd;
    logic                          sel_m;
    logic                          sel_s;
    logic [1:0]                    srdy;
    logic                          strap_ok;
    logic                          addr_hi;
  } ima_core_s;

  ima_core_s s;
  ima_core_s n;

  ima_line_if lk ();

  ima_line_mon #(
    .BUSMON_CYC (BUSMON_CYC)
  ) u_mon (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sda_i (sda_i),
    .scl_i (scl_i),
    .lk    (lk)
  );

  assign lk.mon_en = s.cfg[ima_pkg::CFG_BMON];

  // Pointer walk that wraps inside the message object for back to back reads
  function automatic logic [15:0] ima_next_ptr(input logic [15:0] p);
    logic [15:0] last;
    last = MSG_ADDR + 16'(MSG_SIZE) - 16'h0001;
    if (p == last)
    begin
      ima_next_ptr = MSG_ADDR;
    end
    else
    begin
      ima_next_ptr = p + 16'h0001;
    end
  endfunction : ima_next_ptr

  always_comb
  begin
    logic [ima_pkg::ST_W-1:0] ev;
    logic [ima_pkg::ST_W-1:0] clr;
    logic [6:0]               my_addr;
    logic                     drive;
    ev       = '0;
    clr      = '0;
    my_addr  = s.addr_hi ? ima_pkg::TGT_ADDR_HI : ima_pkg::TGT_ADDR_LO;
    drive    = 1'b0;
    n        = s;
    n.lo     = 1'b0;
    n.pop    = 1'b0;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    n.wb_ack = 1'b0;

    // ==========================================================
    // Address strap, caught once after reset
    n.sel_m = addr_sel_i;
    n.sel_s = s.sel_m;
    n.srdy  = {s.srdy[0], 1'b1};
    if (s.srdy[1] && !s.strap_ok)
    begin
      n.addr_hi  = s.sel_s;
      n.strap_ok = 1'b1;
    end

    // ==========================================================
    // Register slave, answers every access one cycle later
    if (wb_cyc_i && wb_stb_i && !s.wb_ack)
    begin
      n.wb_ack = 1'b1;
      n.wb_dat = '0;
      case (wb_adr_i)
        ima_pkg::REG_CFG:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            n.cfg = wb_dat_i[ima_pkg::CFG_W-1:0];
          end
          n.wb_dat = 32'(s.cfg);
        end
        ima_pkg::REG_STAT:
        begin
          if (!wb_we_i)
          begin
            clr = s.stat;
          end
          n.wb_dat = 32'(s.stat);
        end
        ima_pkg::REG_MASK:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            n.mask = wb_dat_i[ima_pkg::ST_W-1:0];
          end
          n.wb_dat = 32'(s.mask);
        end
        ima_pkg::REG_INFO:
        begin
          n.wb_dat = 32'({s.alert_oe, s.st != ima_pkg::IMA_IDLE, s.st, msg_count_i});
        end
        default:
        begin
          n.wb_dat = '0;
        end
      endcase
    end

    // ==========================================================
    // Byte fetch for reads; count object and empty queue answered locally
    if (s.freq && !s.fetch)
    begin
      n.freq = 1'b0;
      if (s.ptr == CNT_ADDR)
      begin
        n.txb   = msg_count_i;
        n.txv   = 1'b1;
        n.txrid = 1'b0;
        n.ptr   = ima_next_ptr(s.ptr);
      end
      else if (s.ptr == MSG_ADDR && msg_count_i == 8'h00)
      begin
        n.txb   = ima_pkg::RID_INVALID;
        n.txv   = 1'b1;
        n.txrid = 1'b0;
        n.ptr   = ima_next_ptr(s.ptr);
      end
      else
      begin
        n.mem_rd   = 1'b1;
        n.mem_addr = s.ptr;
        n.fetch    = 1'b1;
        n.txrid    = (s.ptr == MSG_ADDR);
      end
    end
    else if (s.fetch && mem_ack_i)
    begin
      n.fetch = 1'b0;
      if (s.st != ima_pkg::IMA_IDLE)
      begin
        n.txb = mem_rdata_i;
        n.txv = 1'b1;
        n.ptr = ima_next_ptr(s.ptr);
      end
    end

    // Report identifier acked and the following byte ready: message consumed
    if (s.pop_pend && s.txv)
    begin
      n.pop      = 1'b1;
      n.pop_pend = 1'b0;
      n.hold0    = 1'b1;
    end

    // ==========================================================
    // Target bit engine
    if (lk.stuck)
    begin
      n.st       = ima_pkg::IMA_IDLE;
      n.sda_oe   = 1'b0;
      n.scl_oe   = 1'b0;
      n.ptr      = s.start;
      n.txv      = 1'b0;
      n.freq     = 1'b0;
      n.pop_pend = 1'b0;
      ev[ima_pkg::ST_STUCK] = 1'b1;
    end
    else if (lk.start)
    begin
      n.st     = ima_pkg::IMA_ADDR;
      n.cnt    = '0;
      n.bidx   = '0;
      n.sda_oe = 1'b0;
    end
    else if (lk.stop)
    begin
      n.st     = ima_pkg::IMA_IDLE;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      n.hold0  = 1'b0;
      if (!s.rw && s.bidx != 2'b00)
      begin
        n.ptr = s.start;
        ev[ima_pkg::ST_WRDONE] = 1'b1;
      end
    end
    else
    begin
      case (s.st)
        ima_pkg::IMA_ADDR, ima_pkg::IMA_WRB:
        begin
          if (lk.rise)
          begin
            n.sh  = {s.sh[6:0], lk.sda};
            n.cnt = s.cnt + 4'h1;
          end
          else if (lk.fall && s.cnt == ima_pkg::BITS_BYTE)
          begin
            n.cnt = '0;
            if (s.st == ima_pkg::IMA_ADDR)
            begin
              if (s.sh[7:1] == my_addr)
              begin
                n.sda_oe = 1'b1;
                n.rw     = s.sh[0];
                n.st     = ima_pkg::IMA_ACK;
                if (s.sh[0])
                begin
                  n.start = s.ptr;
                  n.txv   = 1'b0;
                  n.freq  = 1'b1;
                end
              end
              else
              begin
                n.st = ima_pkg::IMA_IDLE;
              end
            end
            else
            begin
              n.sda_oe = 1'b1;
              n.st     = ima_pkg::IMA_ACK;
              if (s.bidx == 2'b00)
              begin
                n.ptr[7:0] = s.sh;
                n.bidx     = 2'b01;
              end
              else if (s.bidx == 2'b01)
              begin
                n.ptr[15:8] = s.sh;
                n.start     = {s.sh, s.ptr[7:0]};
                n.bidx      = 2'b10;
              end
              else
              begin
                n.mem_wr   = 1'b1;
                n.mem_addr = s.ptr;
                n.mem_wd   = s.sh;
                n.ptr      = s.ptr + 16'h0001;
              end
            end
          end
        end
        ima_pkg::IMA_ACK:
        begin
          if (lk.fall)
          begin
            n.sda_oe = 1'b0;
            n.strc   = '0;
            n.st     = s.rw ? ima_pkg::IMA_LOAD : ima_pkg::IMA_WRB;
            n.scl_oe = s.rw;
          end
        end
        ima_pkg::IMA_LOAD:
        begin
          if (s.txv || s.strc == ima_pkg::TW'(STRETCH_CYC))
          begin
            n.tx     = s.txv ? s.txb : ima_pkg::RID_INVALID;
            n.sda_oe = s.txv ? ~s.txb[7] : 1'b0;
            n.rid_ld = s.txv & s.txrid;
            n.cnt    = '0;
            n.st     = ima_pkg::IMA_RDB;
            n.txv    = 1'b0;
            n.freq   = s.txv;
            ev[ima_pkg::ST_STRTO] = ~s.txv;
          end
          else
          begin
            n.scl_oe = 1'b1;
            n.strc   = s.strc + 1'b1;
          end
        end
        ima_pkg::IMA_RDB:
        begin
          // SCL was held since the fall; let go once the first bit stands
          n.scl_oe = 1'b0;
          if (lk.fall)
          begin
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == ima_pkg::BIT_LAST)
            begin
              n.sda_oe = 1'b0;
              n.st     = ima_pkg::IMA_RACK;
            end
            else
            begin
              n.sda_oe = ~s.tx[6];
              n.tx     = {s.tx[6:0], 1'b0};
            end
          end
        end
        ima_pkg::IMA_RACK:
        begin
          if (lk.rise)
          begin
            n.ackok = ~lk.sda;
            if (!lk.sda && s.rid_ld)
            begin
              n.pop_pend = 1'b1;
            end
          end
          else if (lk.fall)
          begin
            n.strc = '0;
            if (s.ackok)
            begin
              n.st     = ima_pkg::IMA_LOAD;
              n.scl_oe = 1'b1;
            end
            else
            begin
              n.st   = ima_pkg::IMA_IDLE;
              n.ptr  = s.start;
              n.txv  = 1'b0;
              n.freq = 1'b0;
              ev[ima_pkg::ST_RDDONE] = 1'b1;
            end
          end
        end
        default:
        begin
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
        end
      endcase
    end

    // ==========================================================
    // Alert line
    n.prev_cnt = msg_count_i;
    if (s.cfg[ima_pkg::CFG_EDGE])
    begin
      if (msg_count_i > s.prev_cnt)
      begin
        n.edge_cnt = ima_pkg::EW'(ima_pkg::EDGE_CYC);
      end
      else if (s.edge_cnt != '0)
      begin
        n.edge_cnt = s.edge_cnt - 1'b1;
      end
      drive = (s.edge_cnt != '0);
    end
    else if (s.cfg[ima_pkg::CFG_MODE])
    begin
      drive = (msg_count_i != 8'h00);
    end
    else
    begin
      drive = (msg_count_i != 8'h00) && !s.hold0;
    end
    if (s.cfg[ima_pkg::CFG_FORCE])
    begin
      drive = ~s.cfg[ima_pkg::CFG_FLVL];
    end
    n.alert_oe = drive;

    // Set wins over the read clear
    n.stat = (s.stat & ~clr) | ev;
    n.irq  = |(n.stat & n.mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s     <= '0;
      s.cfg <= ima_pkg::CFG_RST;
      s.ptr <= CNT_ADDR;
      s.start <= CNT_ADDR;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_dat_o             = s.wb_dat;
  assign wb_ack_o             = s.wb_ack;
  assign irq_o                = s.irq;
  assign sda_o                = s.lo;
  assign sda_oe_o             = s.sda_oe;
  assign scl_o                = s.lo;
  assign scl_oe_o             = s.scl_oe;
  assign message_alert_n_o    = s.lo;
  assign message_alert_n_oe_o = s.alert_oe;
  assign msg_pop_o            = s.pop;
  assign mem_addr_o           = s.mem_addr;
  assign mem_rd_o             = s.mem_rd;
  assign mem_wr_o             = s.mem_wr;
  assign mem_wdata_o          = s.mem_wd;

endmodule : ima_target

/* verif/ima_target_chk.sv */
`timescale 1ns/1ps
module ima_target_chk #(
  parameter int STRETCH_CYC = 200
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Lines
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        message_alert_n_o,
  input wire logic        message_alert_n_oe_o,
  // Queue
  input wire logic [7:0]  msg_count_i,
  input wire logic        msg_pop_o
);
  int unsigned hold_r;

  // Length of the current clock stretch
  always_ff @(posedge clk_i)
    hold_r <= (rst_i || !scl_oe_o) ? 0 : hold_r + 1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sda_never_high: assert property (sda_o == 1'b0)
    else $error("SDA driven high");
  a_scl_never_high: assert property (scl_o == 1'b0)
    else $error("SCL driven high");
  a_alert_open_drain: assert property (message_alert_n_o == 1'b0)
    else $error("Alert driven high");
  a_stretch_bound: assert property (hold_r <= STRETCH_CYC + 16)
    else $error("Clock stretch too long");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack held");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h0
    |-> wb_dat_o == 32'h0)
    else $error("Unmapped read not zero");
  a_pop_single: assert property (msg_pop_o |=> !msg_pop_o)
    else $error("Pop held");
  a_pop_needs_msg: assert property (msg_pop_o |-> msg_count_i != 8'h00)
    else $error("Pop of empty queue");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !scl_oe_o
    && !message_alert_n_oe_o && !wb_ack_o && !msg_pop_o)
    else $error("Outputs active after reset");

  c_stretch: cover property (hold_r == 20);
  c_pop: cover property (msg_pop_o);
  c_alert_rel: cover property ($fell(message_alert_n_oe_o));
endmodule : ima_target_chk

bind ima_target ima_target_chk #(.STRETCH_CYC(STRETCH_CYC)) u_ima_target_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sda_o, .sda_oe_o, .scl_o,
  .scl_oe_o, .message_alert_n_o, .message_alert_n_oe_o, .msg_count_i, .msg_pop_o);

/* verif/ima_host_bfm.sv */
`timescale 1ns/1ps
module ima_host_bfm (
  input wire logic clk_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic     sda_oe_o,
  output logic     scl_oe_o
);
  initial
  begin
    sda_oe_o = 1'b0;
    scl_oe_o = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hw

  // Release SCL and sit out a stretch, bounded so a stuck target cannot hang us
  task automatic up;
    int n;
    scl_oe_o <= 1'b0;
    n = 0;
    do @(posedge clk_i); while (scl_i !== 1'b1 && ++n < 2000);
    hw(2);
  endtask : up

  task automatic bit_o(input logic b);
    hw(2);
    sda_oe_o <= !b;
    hw(3);
    up;
    scl_oe_o <= 1'b1;
  endtask : bit_o

  // Sample late in the high phase: the target changes SDA a few clocks after SCL falls
  task automatic bit_i(output logic b);
    hw(2);
    sda_oe_o <= 1'b0;
    hw(3);
    up;
    b = sda_i;
    scl_oe_o <= 1'b1;
  endtask : bit_i

  task automatic start;
    sda_oe_o <= 1'b1;
    hw(4);
    scl_oe_o <= 1'b1;
  endtask : start

  task automatic stop;
    hw(2);
    sda_oe_o <= 1'b1;
    hw(2);
    up;
    sda_oe_o <= 1'b0;
    hw(4);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_o(d[i]);
    bit_i(a);
    ack = !a;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_i(d[i]);
    bit_o(last);
  endtask : rbyte
endmodule : ima_host_bfm

/* verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mack = 0, ak;
  logic [7:0]  adr = 0, cnt = 0, rdat = 0;
  logic [31:0] dat = 0, q;
  logic [7:0]  bb [16];
  logic        al [16];
  int          lat = 2, wt = 0, errors = 0, cmp_count = 0;
  wire logic [31:0] wdo;
  wire logic [15:0] maddr;
  wire logic [7:0]  mwd;
  logic [23:0] wm = 0;
  wire logic   ack, irq, sda_oe, scl_oe, al_oe, pop, mrd, hs, hc, mwr;
  // Pull-ups on both bus lines
  wire logic   sda = !(sda_oe | hs);
  wire logic   scl = !(scl_oe | hc);

  initial forever #12.5 clk_i = !clk_i;

  ima_target #(.STRETCH_CYC(200), .BUSMON_CYC(2000)) u_ima_target (.clk_i, .rst_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .irq_o(irq), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .addr_sel_i(1'b0),
    .message_alert_n_o(), .message_alert_n_oe_o(al_oe), .msg_count_i(cnt), .msg_pop_o(pop),
    .mem_addr_o(maddr), .mem_rd_o(mrd), .mem_wr_o(mwr), .mem_wdata_o(mwd), .mem_rdata_i(rdat),
    .mem_ack_i(mack));
  ima_host_bfm u_ima_host_bfm (.clk_i, .sda_i(sda), .scl_i(scl), .sda_oe_o(hs), .scl_oe_o(hc));

  // Object memory with adjustable latency, and the message queue
  always @(posedge clk_i)
  begin
    mack <= 1'b0;
    if (mrd)
    begin
      wt <= lat;
      rdat <= maddr[7:0] ^ 8'h5a;
    end
    else if (wt > 0)
      wt <= wt - 1;
    if (!mrd && wt == 1)
      mack <= 1'b1;
    if (pop)
      cnt <= cnt - 8'h01;
    if (mwr)
      wm <= {maddr, mwd};
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hw

  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
      errors++;
    @(posedge clk_i);
  endtask : wbx

  // Read n bytes at the pointer, last one refused, alert noted after each byte
  task automatic rdn(input int n);
    u_ima_host_bfm.start;
    u_ima_host_bfm.wbyte(8'h95, ak);
    `CHK("addr_ack", 1'b1, ak)
    for (int i = 0; i < n; i++)
    begin
      u_ima_host_bfm.rbyte(i == n - 1, bb[i]);
      hw(16);
      al[i] = al_oe;
    end
    u_ima_host_bfm.stop;
    hw(8);
  endtask : rdn

  task automatic t_regs;
    wbx(0, 8'h00, 0);
    `CHK("cfg_rst", 32'h10, q)
    wbx(1, 8'h00, 32'h1f);
    wbx(0, 8'h00, 0);
    `CHK("cfg_rw", 32'h1f, q)
    wbx(0, 8'h40, 0);
    `CHK("unmapped", 32'h0, q)
    wbx(1, 8'h00, 32'h10);
  endtask : t_regs

  task automatic t_write;
    u_ima_host_bfm.start;
    u_ima_host_bfm.wbyte(8'h94, ak);
    u_ima_host_bfm.wbyte(8'h00, ak);
    u_ima_host_bfm.wbyte(8'h01, ak);
    u_ima_host_bfm.wbyte(8'ha5, ak);
    u_ima_host_bfm.stop;
    `CHK("wr_ack", 1'b1, ak)
    `CHK("mem_wr", 24'h0100a5, wm)
  endtask : t_write

  task automatic t_mode0;
    cnt <= 8'h02;
    hw(4);
    `CHK("alert_on", 1'b1, al_oe)
    rdn(3);
    `CHK("count", 8'h02, bb[0])
    `CHK("rid", 8'h5b, bb[1])
    `CHK("alert_rel", 1'b0, al[2])
    `CHK("alert_again", 1'b1, al_oe)
    rdn(3);
    `CHK("ptr_back", 8'h01, bb[0])
    `CHK("alert_none", 1'b0, al_oe)
    rdn(2);
    `CHK("invalid", 8'hff, bb[1])
    `CHK("irq_masked", 1'b0, irq)
  endtask : t_mode0

  task automatic t_mode1;
    wbx(1, 8'h00, 32'h11);
    cnt <= 8'h02;
    rdn(13);
    `CHK("wrap_rid", 8'h5b, bb[11])
    `CHK("alert_held", 1'b1, al[2])
    `CHK("alert_last", 1'b0, al[12])
    wbx(1, 8'h00, 32'h10);
  endtask : t_mode1

  task automatic t_alert_cfg;
    wbx(1, 8'h00, 32'h14);
    `CHK("force_low", 1'b1, al_oe)
    wbx(1, 8'h00, 32'h1c);
    cnt <= 8'h01;
    hw(4);
    `CHK("force_rel", 1'b0, al_oe)
    wbx(1, 8'h00, 32'h12);
    cnt <= 8'h00;
    hw(2);
    cnt <= 8'h01;
    hw(4);
    `CHK("edge_on", 1'b1, al_oe)
    hw(50);
    `CHK("edge_off", 1'b0, al_oe)
    cnt <= 8'h00;
    wbx(1, 8'h00, 32'h10);
  endtask : t_alert_cfg

  task automatic t_stretch;
    wbx(0, 8'h04, 0);
    wbx(1, 8'h08, 32'h2);
    lat = 400;
    cnt <= 8'h01;
    rdn(2);
    `CHK("timeout_ff", 8'hff, bb[1])
    `CHK("irq_up", 1'b1, irq)
    wbx(0, 8'h04, 0);
    `CHK("stat_to", 1'b1, q[1])
    hw(2);
    `CHK("irq_clr", 1'b0, irq)
    lat = 2;
    hw(300);
    cnt <= 8'h00;
  endtask : t_stretch

  // Hold SCL low past the monitor limit, once with the monitor on and once off
  task automatic t_busmon(input logic [31:0] cfg);
    wbx(1, 8'h00, cfg);
    wbx(0, 8'h04, 0);
    u_ima_host_bfm.scl_oe_o <= 1'b1;
    hw(2100);
    u_ima_host_bfm.scl_oe_o <= 1'b0;
    hw(8);
    `CHK("lines_free", 1'b0, sda_oe | scl_oe)
    wbx(0, 8'h04, 0);
    `CHK("stuck_rst", cfg[4], q[0])
  endtask : t_busmon

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    hw(5);
    rst_i <= 1'b0;
    hw(6);
    t_regs;
    t_write;
    t_mode0;
    t_mode1;
    t_alert_cfg;
    t_stretch;
    t_busmon(32'h10);
    t_busmon(32'h00);
    stop_test;
  end

  initial
  begin
    #2_000_000;
    errors++;
    stop_test;
  end
endmodule : tb_top
